// *** logic/sldis_pkg.sv ***
// Package: register map, field layout, timing counts and carriers for the DMA interrupt service block
// Notes on behaviour
// - Writing link control one with bit zero low clears clock-missing flag
// - Servicing flows run independently in any order
// - Channel interrupt raised only when mask enables
// - Clear select: zero clears on read, one write-one-clears
// - Mux select zero splits lines, one merges
// - Interrupt registers reached directly over APB
// - Upper mask bit enables write of table bit
// - Link control registers reached directly over APB
package sldis_pkg;
    localparam int ADDR_W = 12;
    localparam int NUM_CH = 64;
    localparam int TBL_DEPTH = 64;
    localparam int TBL_AW = 6;

    // Register offsets
    localparam logic [11:0] OFS_LINK_CTRL0 = 12'h000;
    localparam logic [11:0] OFS_LINK_CTRL1 = 12'h00C;
    localparam logic [11:0] OFS_CTX_WMASK_UP = 12'h0DC;
    localparam logic [11:0] OFS_IRQ_STAT0 = 12'h3D0;
    localparam logic [11:0] OFS_IRQ_STAT1 = 12'h3D4;
    localparam logic [11:0] OFS_IRQ_MASK0 = 12'h3D8;
    localparam logic [11:0] OFS_IRQ_MASK1 = 12'h3DC;
    localparam logic [11:0] OFS_DMA_CTRL = 12'h3E0;

    // Field positions
    localparam int LC0_LOCK_BIT = 0;
    localparam int LC0_FRAME_LSB = 8;
    localparam int LC1_MISSING_BIT = 0;
    localparam int LC1_ACTIVE_BIT = 1;
    localparam int CTL_CLR_SEL_BIT = 0;
    localparam int CTL_MUX_SEL_BIT = 1;

    // Reset values
    localparam logic [31:0] RST_CTX_WMASK_UP = 32'h00000000;
    localparam logic [31:0] RST_IRQ_MASK = 32'h00000000;
    localparam logic [31:0] RST_IRQ_STAT = 32'h00000000;
    localparam logic [1:0] RST_DMA_CTRL = 2'h0;

    // Timing: link clock declared missing after this long without a rising edge
    localparam int MCLK_PERIOD_NS = 40;
    localparam int CLK_MISS_NS = 1000;
    localparam int CLK_MISS_CYC = CLK_MISS_NS / MCLK_PERIOD_NS;
    localparam int MISS_CNT_W = 6;
    // Link clocks per frame and good frames needed for lock
    localparam int FRAME_CLKS = 64;
    localparam int FRAME_CNT_W = 7;
    localparam int LOCK_FRAMES = 3;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
    } sldis_apb_req_t;

    typedef struct packed {
        logic missing_evt;
        logic active;
        logic locked;
        logic frame_tick;
    } sldis_link_st_t;
endpackage

// *** logic/sldis_link_mon.sv ***
// Link clock monitor: clock presence, frame sync lock and frame ticks
`timescale 1ns/1ps
module sldis_link_mon (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    // Link pins
    input wire logic link_clk_pin,
    input wire logic link_sync_pin,
    // Status toward the register side
    output sldis_pkg::sldis_link_st_t link_st
);
    import sldis_pkg::*;

    logic clk_s1_reg, clk_s2_reg, clk_s3_reg;
    logic sync_s1_reg, sync_s2_reg;
    logic [MISS_CNT_W-1:0] miss_cnt_reg;
    logic [FRAME_CNT_W-1:0] bit_cnt_reg;
    logic [2:0] good_cnt_reg;
    sldis_link_st_t st_reg;

    wire link_rise = clk_s2_reg && !clk_s3_reg;
    wire miss_hit = (miss_cnt_reg == MISS_CNT_W'(CLK_MISS_CYC));
    wire sync_seen = link_rise && sync_s2_reg;
    wire on_slot = (bit_cnt_reg == FRAME_CNT_W'(FRAME_CLKS - 1));
    wire frame_overrun = link_rise && !sync_s2_reg && on_slot;
    wire locked_now = (good_cnt_reg == 3'(LOCK_FRAMES));

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clk_s1_reg <= 1'b0;
            clk_s2_reg <= 1'b0;
            clk_s3_reg <= 1'b0;
            sync_s1_reg <= 1'b0;
            sync_s2_reg <= 1'b0;
        end else if (ce) begin
            clk_s1_reg <= link_clk_pin;
            clk_s2_reg <= clk_s1_reg;
            clk_s3_reg <= clk_s2_reg;
            sync_s1_reg <= link_sync_pin;
            sync_s2_reg <= sync_s1_reg;
        end
    end

    // Miss counter saturates so the missing event fires once per outage
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            miss_cnt_reg <= '0;
        end else if (ce) begin
            if (link_rise) begin
                miss_cnt_reg <= '0;
            end else if (!miss_hit) begin
                miss_cnt_reg <= miss_cnt_reg + MISS_CNT_W'(1);
            end
        end
    end

    // A sync off its slot, a missed sync or a stopped clock restarts lock acquisition
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_reg <= '0;
            good_cnt_reg <= '0;
        end else if (ce) begin
            if (miss_hit || frame_overrun) begin
                good_cnt_reg <= '0;
                bit_cnt_reg <= '0;
            end else if (sync_seen) begin
                bit_cnt_reg <= '0;
                if (good_cnt_reg == '0 || on_slot) begin
                    good_cnt_reg <= locked_now ? good_cnt_reg : good_cnt_reg + 3'(1);
                end else begin
                    good_cnt_reg <= 3'(1);
                end
            end else if (link_rise) begin
                bit_cnt_reg <= bit_cnt_reg + FRAME_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg.missing_evt <= miss_hit && (miss_cnt_reg != '0) && !st_reg.missing_evt && st_reg.active;
            st_reg.active <= !miss_hit;
            st_reg.locked <= locked_now && !miss_hit;
            // A sync that lands on the timeout edge must not tick while lock is being dropped
            st_reg.frame_tick <= sync_seen && locked_now && on_slot && !miss_hit;
        end
    end

    assign link_st = st_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_lock_lost_miss: assert property (ce && miss_hit |=> !link_st.locked)
        else $error("lock held while link clock missing");
    a_tick_only_locked: assert property (link_st.frame_tick |-> link_st.locked)
        else $error("frame tick without lock");
endmodule

// *** logic/sldis_top.sv ***
// DMA channel interrupt service, link status registers and context write mask
`timescale 1ns/1ps
module sldis_top (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    // APB slave
    input sldis_pkg::sldis_apb_req_t apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel events from DMA engine, one-cycle pulses
    input wire logic [sldis_pkg::NUM_CH-1:0] ch_event,
    // Interrupt lines
    output logic irq0,
    output logic irq1,
    // Channel table upper word port
    input wire logic tbl_we,
    input wire logic [sldis_pkg::TBL_AW-1:0] tbl_addr,
    input wire logic [31:0] tbl_wdata,
    output logic [31:0] tbl_rdata,
    // Link pins
    input wire logic link_clk_pin,
    input wire logic link_sync_pin
);
    import sldis_pkg::*;

    logic [NUM_CH-1:0] st_reg, st_next, mask_reg;
    logic [31:0] wmask_reg;
    logic clr_sel_reg, mux_sel_reg;
    logic missing_reg;
    logic [7:0] frame_cnt_reg;
    logic [31:0] prdata_reg;
    logic irq0_reg, irq1_reg;
    logic [31:0] tbl_rdata_reg;
    logic [31:0] tbl_mem [TBL_DEPTH];
    sldis_link_st_t link_st;

    sldis_link_mon u_link (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .link_clk_pin(link_clk_pin),
        .link_sync_pin(link_sync_pin),
        .link_st(link_st)
    );

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
        hit = (a == ofs);
    endfunction

    // Decode; pready follows ce, so an access completes in its first access cycle with ce high
    wire setup = apb_req.sel && !apb_req.enable;
    wire access = apb_req.sel && apb_req.enable && ce;
    wire wr = access && apb_req.write;
    wire rd = access && !apb_req.write;
    wire [ADDR_W-1:0] a = apb_req.addr;
    wire [31:0] wd = apb_req.wdata;
    wire sel_lc0 = hit(a, OFS_LINK_CTRL0);
    wire sel_lc1 = hit(a, OFS_LINK_CTRL1);
    wire sel_wm = hit(a, OFS_CTX_WMASK_UP);
    wire sel_st0 = hit(a, OFS_IRQ_STAT0);
    wire sel_st1 = hit(a, OFS_IRQ_STAT1);
    wire sel_mk0 = hit(a, OFS_IRQ_MASK0);
    wire sel_mk1 = hit(a, OFS_IRQ_MASK1);
    wire sel_ctl = hit(a, OFS_DMA_CTRL);
    wire mapped = sel_lc0 || sel_lc1 || sel_wm || sel_st0 || sel_st1 || sel_mk0 || sel_mk1 || sel_ctl;

    // Read data is captured in the setup cycle so prdata comes from a flip-flop
    wire [31:0] lc0_val = (32'(link_st.locked) << LC0_LOCK_BIT) | (32'(frame_cnt_reg) << LC0_FRAME_LSB);
    wire [31:0] lc1_val = (32'(missing_reg) << LC1_MISSING_BIT) | (32'(link_st.active) << LC1_ACTIVE_BIT);
    wire [31:0] ctl_val = (32'(clr_sel_reg) << CTL_CLR_SEL_BIT) | (32'(mux_sel_reg) << CTL_MUX_SEL_BIT);
    logic [31:0] rd_mux;
    assign rd_mux = sel_lc0 ? lc0_val :
                    sel_lc1 ? lc1_val :
                    sel_wm ? wmask_reg :
                    sel_st0 ? st_reg[31:0] :
                    sel_st1 ? st_reg[63:32] :
                    sel_mk0 ? mask_reg[31:0] :
                    sel_mk1 ? mask_reg[63:32] :
                    sel_ctl ? ctl_val : 32'h00000000;

    assign pready = ce;
    assign pslverr = apb_req.sel && apb_req.enable && !mapped;
    assign prdata = prdata_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_reg <= 32'h00000000;
        end else if (ce && setup) begin
            prdata_reg <= rd_mux;
        end
    end

    // Clear-on-read removes exactly the bits returned; a new event in the same cycle survives
    wire [31:0] clr_lo = ((rd && !clr_sel_reg && sel_st0) ? prdata_reg : 32'h00000000) |
                         ((wr && clr_sel_reg && sel_st0) ? wd : 32'h00000000);
    wire [31:0] clr_hi = ((rd && !clr_sel_reg && sel_st1) ? prdata_reg : 32'h00000000) |
                         ((wr && clr_sel_reg && sel_st1) ? wd : 32'h00000000);
    assign st_next = (st_reg & ~{clr_hi, clr_lo}) | ch_event;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= {RST_IRQ_STAT, RST_IRQ_STAT};
            mask_reg <= {RST_IRQ_MASK, RST_IRQ_MASK};
            {mux_sel_reg, clr_sel_reg} <= RST_DMA_CTRL;
            wmask_reg <= RST_CTX_WMASK_UP;
        end else if (ce) begin
            st_reg <= st_next;
            if (wr && sel_mk0) mask_reg[31:0] <= wd;
            if (wr && sel_mk1) mask_reg[63:32] <= wd;
            if (wr && sel_ctl) begin
                clr_sel_reg <= wd[CTL_CLR_SEL_BIT];
                mux_sel_reg <= wd[CTL_MUX_SEL_BIT];
            end
            if (wr && sel_wm) wmask_reg <= wd;
        end
    end

    // Status, link flags and command polling share no sequencing, so software may interleave them
    wire [NUM_CH-1:0] pend = st_reg & mask_reg;
    wire line0 = mux_sel_reg ? |pend : |pend[31:0];
    wire line1 = !mux_sel_reg && |pend[63:32];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq0_reg <= 1'b0;
            irq1_reg <= 1'b0;
        end else if (ce) begin
            irq0_reg <= line0;
            irq1_reg <= line1;
        end
    end
    assign irq0 = irq0_reg;
    assign irq1 = irq1_reg;

    // Clock-missing flag: any link control one write with bit zero low clears it, a fresh outage wins
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            missing_reg <= 1'b0;
            frame_cnt_reg <= 8'h00;
        end else if (ce) begin
            if (link_st.missing_evt) begin
                missing_reg <= 1'b1;
            end else if (wr && sel_lc1 && !wd[LC1_MISSING_BIT]) begin
                missing_reg <= 1'b0;
            end
            if (link_st.frame_tick) frame_cnt_reg <= frame_cnt_reg + 8'h01;
        end
    end

    // Upper table word: masked bits keep their stored value
    wire [31:0] tbl_old = tbl_mem[tbl_addr];
    wire [31:0] tbl_merged = (tbl_wdata & wmask_reg) | (tbl_old & ~wmask_reg);
    always_ff @(posedge mclk) begin
        if (ce && tbl_we) tbl_mem[tbl_addr] <= tbl_merged;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tbl_rdata_reg <= 32'h00000000;
        end else if (ce) begin
            tbl_rdata_reg <= tbl_mem[tbl_addr];
        end
    end
    assign tbl_rdata = tbl_rdata_reg;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_st0_read;
        ce && apb_req.sel && apb_req.enable && !apb_req.write && (apb_req.addr == OFS_IRQ_STAT0) && !clr_sel_reg;
    endsequence
    sequence s_st0_w1c;
        ce && apb_req.sel && apb_req.enable && apb_req.write && (apb_req.addr == OFS_IRQ_STAT0) && clr_sel_reg;
    endsequence
    sequence s_st1_read;
        ce && apb_req.sel && apb_req.enable && !apb_req.write && (apb_req.addr == OFS_IRQ_STAT1) && !clr_sel_reg;
    endsequence
    sequence s_st1_w1c;
        ce && apb_req.sel && apb_req.enable && apb_req.write && (apb_req.addr == OFS_IRQ_STAT1) && clr_sel_reg;
    endsequence
    sequence s_lc0_setup;
        ce && apb_req.sel && !apb_req.enable && (apb_req.addr == OFS_LINK_CTRL0);
    endsequence

    a_irq_split_map: assert property (ce && !mux_sel_reg && |(st_reg[63:32] & mask_reg[63:32]) |=> irq1)
        else $error("upper channels failed to raise line one");
    a_irq_merge_map: assert property (ce && mux_sel_reg |=> !irq1 && (irq0 == $past(|pend)))
        else $error("merged mode drove line one or missed line zero");
    a_mask_gates: assert property (ce && ((st_reg & mask_reg) == '0) |=> !irq0 && !irq1)
        else $error("interrupt raised by a masked channel");
    a_irq_holds: assert property (ce && |(st_reg[31:0] & mask_reg[31:0]) |=> irq0)
        else $error("line zero dropped with pending enabled channel");
    a_read_clears: assert property (s_st0_read ##0 (ch_event[31:0] == '0)
        |=> (st_reg[31:0] & $past(prdata_reg)) == '0)
        else $error("read did not clear returned status bits");
    a_w1c_clears: assert property (s_st0_w1c ##0 (ch_event[31:0] == '0)
        |=> (st_reg[31:0] & $past(apb_req.wdata)) == '0)
        else $error("write one did not clear status bits");
    a_set_wins: assert property (ce && ch_event[0] |=> st_reg[0])
        else $error("event lost against a clear");
    a_miss_clear: assert property (ce && wr && sel_lc1 && !wd[LC1_MISSING_BIT] && !link_st.missing_evt
        |=> !missing_reg)
        else $error("clock missing flag not cleared by write");
    a_lock_readback: assert property (s_lc0_setup |=> prdata[LC0_LOCK_BIT] == $past(link_st.locked))
        else $error("lock flag not returned on read");
    a_mask_write: assert property (wr && sel_mk0 |=> mask_reg[31:0] == $past(wd))
        else $error("mask write did not land in its access cycle");
    a_st1_read_clears: assert property (s_st1_read ##0 (ch_event[63:32] == '0)
        |=> (st_reg[63:32] & $past(prdata_reg)) == '0)
        else $error("read did not clear returned upper status bits");
    a_st1_w1c_clears: assert property (s_st1_w1c ##0 (ch_event[63:32] == '0)
        |=> (st_reg[63:32] & $past(apb_req.wdata)) == '0)
        else $error("write one did not clear upper status bits");
    // Events arriving while frozen are dropped, so a stalled system clock loses them
    a_freeze_hold: assert property (!ce |=> $stable(st_reg) && $stable(mask_reg) && $stable(missing_reg))
        else $error("state moved while clock enable low");
    a_miss_sets: assert property (ce && link_st.missing_evt |=> missing_reg)
        else $error("clock missing event not recorded");
    a_tbl_write: assert property (ce && tbl_we |=>
        ((tbl_mem[$past(tbl_addr)] ^ $past(tbl_wdata)) & $past(wmask_reg)) == '0)
        else $error("enabled table bits not written");
    a_tbl_keep: assert property (ce && tbl_we |=>
        ((tbl_mem[$past(tbl_addr)] ^ $past(tbl_old)) & ~$past(wmask_reg)) == '0)
        else $error("masked table bits changed");
endmodule

// *** sim/sldis_link_partner.sv ***
// Far-end link model: frames of link clocks with a sync pulse on the first clock
`timescale 1ns/1ps
module sldis_link_partner (
    // Control from the bench
    input wire logic run,
    // Link pins
    output logic link_clk,
    output logic link_sync
);
    import sldis_pkg::*;
    int n;
    initial begin
        link_clk = 1'b0;
        link_sync = 1'b1;
        forever begin
            wait (run);
            // Odd offset keeps link edges 7 ns away from mclk edges
            #7;
            while (run) begin
                for (n = 0; n < FRAME_CLKS; n++) begin
                    link_sync = (n == 0);
                    #160 link_clk = 1'b1;
                    #160 link_clk = 1'b0;
                end
            end
            // Clock stands still between bursts; sync shows the inverse of its last level
            link_sync = 1'b1;
        end
    end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for the DMA interrupt service block
`timescale 1ns/1ps
module tb_top;
    import sldis_pkg::*;
    logic mclk, reset_n, ce, irq0, irq1, pready, pslverr, tbl_we, link_clk, link_sync, run;
    sldis_apb_req_t apb_req;
    logic [31:0] prdata, tbl_wdata, tbl_rdata, rd, part, mk;
    logic [63:0] ch_event, st, msk, ev;
    logic [5:0] tbl_addr;
    logic [31:0] mem [4];
    logic clr_mode, mux_mode, er;
    logic [7:0] f1;
    int miscompares = 0;
    int total_checks = 0;
    int m, h, a;

    sldis_top u_sldis_top (.mclk(mclk), .reset_n(reset_n), .ce(ce), .apb_req(apb_req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ch_event(ch_event), .irq0(irq0), .irq1(irq1), .tbl_we(tbl_we),
        .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_rdata(tbl_rdata), .link_clk_pin(link_clk),
        .link_sync_pin(link_sync));
    sldis_link_partner u_sldis_link_partner (.run(run), .link_clk(link_clk), .link_sync(link_sync));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int i;
        @(negedge mclk);
        apb_req = '{1'b1, 1'b0, w, ad, wd};
        @(negedge mclk);
        apb_req.enable = 1'b1;
        // Request held through every edge until pready is sampled high; data taken at that edge
        @(posedge mclk);
        for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge mclk);
        if (pready !== 1'b1) begin
            chk("pready", 32'h00000001, {31'h0, pready});
            conclude();
        end else begin
            rd = prdata;
            er = pslverr;
            @(negedge mclk);
            apb_req.sel = 1'b0;
            apb_req.enable = 1'b0;
        end
    endtask

    task automatic rdm(input string nm, input logic [11:0] ad, input logic [31:0] k, input logic [31:0] e);
        apb(1'b0, ad, 32'h00000000);
        chk(nm, e & k, rd & k);
    endtask

    task automatic poll(input logic [11:0] ad, input int b, input logic v);
        int i;
        for (i = 0; i < 2000; i++) begin
            apb(1'b0, ad, 32'h00000000);
            if (rd[b] === v) return;
        end
        chk("poll", {31'h0, v}, {31'h0, rd[b]});
        conclude();
    endtask

    function automatic logic [31:0] exp_irq();
        logic [63:0] p;
        p = st & msk;
        return mux_mode ? {31'h0, |p} : {30'h0, |p[63:32], |p[31:0]};
    endfunction

    task automatic tbl(input logic w, input int ad, input logic [31:0] d);
        @(negedge mclk);
        tbl_we = w;
        tbl_addr = ad[5:0];
        tbl_wdata = d;
        @(negedge mclk);
        tbl_we = 1'b0;
    endtask

    initial begin
        reset_n = 1'b0;
        ce = 1'b1;
        run = 1'b0;
        apb_req = '0;
        ch_event = '0;
        tbl_we = 1'b0;
        tbl_addr = 6'h00;
        tbl_wdata = 32'h00000000;
        st = '0;
        void'($urandom(32'h3803099B));
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        rdm("wmask_rst", OFS_CTX_WMASK_UP, 32'hFFFFFFFF, 32'h00000000);
        rdm("mask0_rst", OFS_IRQ_MASK0, 32'hFFFFFFFF, 32'h00000000);
        rdm("ctrl_rst", OFS_DMA_CTRL, 32'h00000003, 32'h00000000);
        apb(1'b0, 12'h004, 32'h00000000);
        chk("unmapped_err", 32'h00000001, {31'h0, er});
        $display("test reset_map done");
        for (m = 0; m < 4; m++) begin
            clr_mode = m[0];
            mux_mode = m[1];
            apb(1'b1, OFS_DMA_CTRL, {30'h0, mux_mode, clr_mode});
            rdm("ctrl", OFS_DMA_CTRL, 32'h00000003, {30'h0, mux_mode, clr_mode});
            msk = {$urandom, $urandom};
            apb(1'b1, OFS_IRQ_MASK0, msk[31:0]);
            apb(1'b1, OFS_IRQ_MASK1, msk[63:32]);
            rdm("mask1", OFS_IRQ_MASK1, 32'hFFFFFFFF, msk[63:32]);
            ev = {$urandom, $urandom};
            @(negedge mclk);
            ch_event = ev;
            @(negedge mclk);
            ch_event = '0;
            st = st | ev;
            repeat (3) @(negedge mclk);
            chk("irq", exp_irq(), {30'h0, irq1, irq0});
            for (h = 0; h < 2; h++) begin
                part = h ? st[63:32] : st[31:0];
                rdm("stat", h ? OFS_IRQ_STAT1 : OFS_IRQ_STAT0, 32'hFFFFFFFF, part);
                if (clr_mode) begin
                    // Write-one-clear: a partial write must leave the other bits pending
                    apb(1'b1, h ? OFS_IRQ_STAT1 : OFS_IRQ_STAT0, part & 32'h55555555);
                    rdm("stat_w1c", h ? OFS_IRQ_STAT1 : OFS_IRQ_STAT0, 32'hFFFFFFFF, part & 32'hAAAAAAAA);
                    apb(1'b1, h ? OFS_IRQ_STAT1 : OFS_IRQ_STAT0, 32'hFFFFFFFF);
                end
                if (h) st[63:32] = '0;
                else st[31:0] = '0;
                rdm("stat_clr", h ? OFS_IRQ_STAT1 : OFS_IRQ_STAT0, 32'hFFFFFFFF, 32'h00000000);
                repeat (3) @(negedge mclk);
                chk("irq_clr", exp_irq(), {30'h0, irq1, irq0});
            end
        end
        $display("test irq_service done");
        // Events offered while the clock enable is low must leave no trace
        @(negedge mclk);
        ce = 1'b0;
        ch_event = {$urandom, $urandom};
        @(negedge mclk);
        ch_event = '0;
        ce = 1'b1;
        rdm("freeze_st0", OFS_IRQ_STAT0, 32'hFFFFFFFF, 32'h00000000);
        rdm("freeze_st1", OFS_IRQ_STAT1, 32'hFFFFFFFF, 32'h00000000);
        chk("freeze_irq", 32'h00000000, {30'h0, irq1, irq0});
        $display("test ce_freeze done");
        apb(1'b1, OFS_CTX_WMASK_UP, 32'hFFFFFFFF);
        for (a = 0; a < 4; a++) begin
            mem[a] = $urandom;
            tbl(1'b1, a, mem[a]);
        end
        mk = $urandom;
        apb(1'b1, OFS_CTX_WMASK_UP, mk);
        rdm("wmask", OFS_CTX_WMASK_UP, 32'hFFFFFFFF, mk);
        for (a = 0; a < 4; a++) begin
            part = $urandom;
            mem[a] = (part & mk) | (mem[a] & ~mk);
            tbl(1'b1, a, part);
        end
        for (a = 0; a < 4; a++) begin
            tbl(1'b0, a, 32'h00000000);
            chk("table", mem[a], tbl_rdata);
        end
        $display("test table_mask done");
        run = 1'b1;
        poll(OFS_LINK_CTRL0, LC0_LOCK_BIT, 1'b1);
        // The idle link before start-up has already raised the missing flag: clear, wait, check again
        apb(1'b1, OFS_LINK_CTRL1, 32'h00000000);
        @(negedge mclk);
        rdm("link_ok", OFS_LINK_CTRL1, 32'h00000003, 32'h00000002);
        apb(1'b0, OFS_LINK_CTRL0, 32'h00000000);
        f1 = rd[15:8];
        repeat (4 * FRAME_CLKS * 8) @(negedge mclk);
        apb(1'b0, OFS_LINK_CTRL0, 32'h00000000);
        // Read phase within a frame allows one extra tick
        chk("frames", 32'h00000001, {31'h0, (rd[15:8] - f1 == 8'h04) || (rd[15:8] - f1 == 8'h05)});
        run = 1'b0;
        poll(OFS_LINK_CTRL1, LC1_MISSING_BIT, 1'b1);
        run = 1'b1;
        repeat (20) @(negedge mclk);
        apb(1'b1, OFS_LINK_CTRL1, 32'h00000000);
        @(negedge mclk);
        rdm("missing_clr", OFS_LINK_CTRL1, 32'h00000001, 32'h00000000);
        $display("test link_flags done");
        conclude();
    end
endmodule
